//--- rtl/wdt_pkg.sv
// constants and types for the windowed countdown watchdog
package wdt_pkg;
  localparam int unsigned CLK_MHZ            = 100;
  localparam int unsigned STEP_CYCLES        = 49152;
  localparam int unsigned WAKE_DELAY_CYCLES  = 4096;
  localparam int unsigned RESET_PULSE_TIME_NS = 1000;
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] CTRL_OFFSET         = 4'hc;
  localparam int unsigned ACT_BIT_POS        = 7;
  localparam int unsigned TOP_BIT_POS        = 6;
  localparam logic [6:0] COUNT_RESET         = 7'h7f;
  localparam logic       ACT_RESET           = 1'b0;
  localparam logic [6:0] TOP_CROSS_FROM      = 7'h40;

  typedef struct packed {
    logic       activation_bit;
    logic [6:0] countdown_value;
  } control_word_s;

  typedef struct packed {
    logic hw_activation;
    logic reset_on_halt;
  } options_s;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_HALT  = 2'b01,
    ST_WAKE  = 2'b10
  } power_state_e;
endpackage : wdt_pkg

//--- rtl/wdt_prescaler.sv
// machine-cycle prescaler producing one step pulse per block of cycles
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int unsigned STEP = 49152
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic restart,
  input  wire logic run,
  output logic      step
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  localparam logic [15:0] LAST = 16'(STEP - 1);
  wire at_last = (cnt_reg == LAST);
  assign cnt_next = restart ? 16'h0000 :
                    !run ? cnt_reg :
                    at_last ? 16'h0000 : cnt_reg + 16'h0001;
  assign step = run && !restart && at_last;
  always_ff @(posedge sys_clk) begin
    if (srst) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_next;
  end
endmodule : wdt_prescaler

//--- rtl/wdt_pulse.sv
// stretches a one-cycle fire request into a low reset pulse on the pin
`timescale 1ns/1ps
module wdt_pulse #(
  parameter int unsigned WIDTH = 100
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic fire,
  output logic      reset_n,
  output logic      busy
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  localparam logic [15:0] LOAD = 16'(WIDTH);
  assign cnt_next = fire ? LOAD : (cnt_reg != 16'h0000) ? cnt_reg - 16'h0001 : cnt_reg;
  assign busy = (cnt_reg != 16'h0000);
  always_ff @(posedge sys_clk) begin
    if (srst) cnt_reg <= 16'h0000;
    else cnt_reg <= cnt_next;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) reset_n <= 1'b1;
    else reset_n <= !(cnt_next != 16'h0000);
  end
endmodule : wdt_pulse

//--- rtl/windowed_countdown_watchdog.sv
// watchdog top: control word, countdown, halt handling and reset request
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Function
// [R01] count steps down every 49152 cycles
// [R02] counter runs even while inactive
// [R03] crossing 40h to 3Fh fires reset pulse
// [R04] six low bits give steps to reset
// [R05] software refreshes control word regularly
// [R06] software refresh value lies FFh to C0h
// [R07] timeout spans 6.144 to 393.216 ms; at 100 MHz the code gives 0.49152 to 31.45728 ms
// [R08] inactive after reset, only reset deactivates
// [R09] write active with top clear resets
// [R10] hardware option forces watchdog active
// [R11] reset-on-halt option resets at halt
// [R12] halt stops counting and withholds reset
// [R13] interrupt wake resumes after 4096 clocks
// [R14] software refreshes before halt
// [R15] bit7 activation, bits 6:0 counter
// [R16] activation set by software, cleared by reset
// [R17] write loads counter, restarts prescaler, ORs
// [R18] option inputs sampled at reset release
module windowed_countdown_watchdog (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       opt_hw_activation,
  input  wire logic       opt_reset_on_halt,
  input  wire logic       halt_exec,
  input  wire logic       ext_wake_irq,
  output logic            wdt_reset_n,
  output logic            wdt_reset_req,
  output logic            halted
);
  wdt_pkg::control_word_s ctrl_reg;
  wdt_pkg::control_word_s ctrl_next;
  wdt_pkg::options_s      opt_reg;
  wdt_pkg::options_s      opt_next;
  wdt_pkg::power_state_e  pstate_reg;
  wdt_pkg::power_state_e  pstate_next;
  logic                   opt_load_reg;
  logic [12:0]            wake_cnt_reg;
  logic [12:0]            wake_cnt_next;
  logic                   step;
  logic                   pulse_busy;

  localparam logic [12:0] WAKE_LAST = 13'(wdt_pkg::WAKE_DELAY_CYCLES - 1);

  // decode and effective activation
  wire ctrl_sel  = (reg_addr == wdt_pkg::CTRL_OFFSET);
  wire ctrl_wr   = reg_wr && ctrl_sel;
  wire active    = ctrl_reg.activation_bit || opt_reg.hw_activation;      // [R10]
  wire counting  = (pstate_reg == wdt_pkg::ST_RUN);                       // [R12]
  wire cnt_step  = step && counting;                                       // [R01] [R02]
  wire crossing  = cnt_step && (ctrl_reg.countdown_value == wdt_pkg::TOP_CROSS_FROM);
  wire wr_act    = reg_wdata[wdt_pkg::ACT_BIT_POS] || ctrl_reg.activation_bit; // [R16]
  wire wr_fire   = ctrl_wr && (wr_act || opt_reg.hw_activation)
                   && !reg_wdata[wdt_pkg::TOP_BIT_POS];                    // [R09]
  wire cross_fire = crossing && active && !ctrl_wr;                        // [R03] [R04]
  wire halt_fire = halt_exec && counting && active && opt_reg.reset_on_halt; // [R11]
  wire fire      = (wr_fire || cross_fire || halt_fire) && !pulse_busy;

  // control word: write loads value and ORs activation
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next.activation_bit  = wr_act;                                  // [R17] [R08]
      ctrl_next.countdown_value = reg_wdata[6:0];                          // [R17] [R15]
    end else if (cnt_step) begin
      ctrl_next.countdown_value = ctrl_reg.countdown_value - 7'h01;        // [R01]
    end
  end

  // options captured one cycle after reset release
  assign opt_next = opt_load_reg ? '{hw_activation: opt_hw_activation,
                                     reset_on_halt: opt_reset_on_halt} : opt_reg; // [R18]

  // halt and wake sequencing
  always_comb begin
    pstate_next   = pstate_reg;
    wake_cnt_next = wake_cnt_reg;
    case (pstate_reg)
      wdt_pkg::ST_RUN: begin
        if (halt_exec && !(active && opt_reg.reset_on_halt)) begin
          pstate_next = wdt_pkg::ST_HALT;                                  // [R12]
        end
      end
      wdt_pkg::ST_HALT: begin
        if (ext_wake_irq) begin
          pstate_next   = wdt_pkg::ST_WAKE;
          wake_cnt_next = 13'h0000;
        end
      end
      wdt_pkg::ST_WAKE: begin
        if (wake_cnt_reg == WAKE_LAST) begin
          pstate_next = wdt_pkg::ST_RUN;                                   // [R13]
        end else begin
          wake_cnt_next = wake_cnt_reg + 13'h0001;
        end
      end
      default: begin
        pstate_next = wdt_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= '{activation_bit: wdt_pkg::ACT_RESET,
                    countdown_value: wdt_pkg::COUNT_RESET};                 // [R08] [R16]
      opt_reg      <= '{hw_activation: 1'b0, reset_on_halt: 1'b0};
      opt_load_reg <= 1'b1;
      pstate_reg   <= wdt_pkg::ST_RUN;
      wake_cnt_reg <= 13'h0000;
    end else begin
      ctrl_reg     <= ctrl_next;
      opt_reg      <= opt_next;
      opt_load_reg <= 1'b0;
      pstate_reg   <= pstate_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  // read data one cycle after the read strobe
  wire [7:0] rd_mux = ctrl_sel ? {active, ctrl_reg.countdown_value} : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (srst) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rd_mux;
    else reg_rdata <= 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) wdt_reset_req <= 1'b0;
    else wdt_reset_req <= fire;
  end

  assign halted = (pstate_reg != wdt_pkg::ST_RUN);

  wdt_prescaler #(
    .STEP (wdt_pkg::STEP_CYCLES)                                            // [R07]
  ) u_prescaler (
    .sys_clk (sys_clk),
    .srst    (srst),
    .restart (ctrl_wr),                                                     // [R17]
    .run     (counting),                                                    // [R12]
    .step    (step)
  );

  wdt_pulse #(
    .WIDTH (wdt_pkg::RESET_PULSE_CYCLES)
  ) u_pulse (
    .sys_clk (sys_clk),
    .srst    (srst),
    .fire    (fire),                                                        // [R03]
    .reset_n (wdt_reset_n),
    .busy    (pulse_busy)
  );
endmodule : windowed_countdown_watchdog

//--- test/wdt_asserts.sv
// port assertions for the countdown watchdog
`timescale 1ns/1ps
module wdt_asserts (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       opt_hw_activation,
  input wire logic       opt_reset_on_halt,
  input wire logic       halt_exec,
  input wire logic       ext_wake_irq,
  input wire logic       wdt_reset_n,
  input wire logic       wdt_reset_req,
  input wire logic       halted
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [7:0]  low_cnt;
  logic [12:0] wake_age;
  wire         ctrl_wr = reg_wr && reg_addr == 4'hc;
  always_ff @(posedge sys_clk) begin
    low_cnt  <= (srst || wdt_reset_n) ? 8'h00 : low_cnt + 8'h01;
    wake_age <= (srst || ext_wake_irq) ? 13'h0000 : wake_age + {12'h000, ~&wake_age};
  end
  sequence halt_s;
    halt_exec && !opt_reset_on_halt && wdt_reset_n;
  endsequence
  AST_REQ_ONE: assert property (wdt_reset_req |-> !wdt_reset_n ##1 !wdt_reset_req)
    else $error("req not one cycle");
  AST_PULSE_LEN: assert property ($rose(wdt_reset_n) |-> low_cnt == 8'h64)
    else $error("pulse length");
  AST_SW_RESET: assert property (ctrl_wr && reg_wdata[7] && !reg_wdata[6] && wdt_reset_n
    |=> wdt_reset_req) else $error("no software reset");
  AST_REFRESH: assert property (ctrl_wr && reg_wdata[6] && !halt_exec |=> !wdt_reset_req)
    else $error("refresh fired");
  AST_HW_ACT: assert property (reg_rd && reg_addr == 4'hc && opt_hw_activation
    |=> reg_rdata[7]) else $error("hw activation");
  AST_UNMAPPED: assert property (reg_rd && reg_addr != 4'hc |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  AST_HALT_RST: assert property (halt_exec && opt_reset_on_halt && opt_hw_activation
    && wdt_reset_n && !halted |=> wdt_reset_req) else $error("halt reset");
  AST_HALT_IN: assert property (halt_s |=> halted) else $error("halt entry");
  AST_HALT_QUIET: assert property (halted && $past(halted) |-> !wdt_reset_req)
    else $error("fire in halt");
  AST_WAKE: assert property ($fell(halted) |-> wake_age >= 13'h0ffe && wake_age <= 13'h1004)
    else $error("wake delay");
endmodule : wdt_asserts

//--- test/testbench.sv
// self-checking bench for the countdown watchdog
`timescale 1ns/1ps
module testbench;
  logic       sys_clk, srst, reg_wr, reg_rd, halt_exec, ext_wake_irq;
  logic       opt_hw_activation, opt_reset_on_halt, wdt_reset_n, wdt_reset_req, halted;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cyc = 0;
  windowed_countdown_watchdog DUT (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .opt_hw_activation, .opt_reset_on_halt, .halt_exec, .ext_wake_irq,
    .wdt_reset_n, .wdt_reset_req, .halted);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= 4'hc;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    tick(1);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    tick(1);
    reg_rd <= 1'b0;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic hit(input logic wake);
    @(posedge sys_clk);
    halt_exec    <= !wake;
    ext_wake_irq <= wake;
    tick(1);
    halt_exec    <= 1'b0;
    ext_wake_irq <= 1'b0;
  endtask : hit
  task automatic rst(input logic hw, input logic roh);
    @(posedge sys_clk);
    srst              <= 1'b1;
    opt_hw_activation <= hw;
    opt_reset_on_halt <= roh;
    tick(16);
    srst <= 1'b0;
    tick(2);
  endtask : rst
  task automatic t_sw;
    rd(4'hc, 8'h7f);
    rd(4'h3, 8'h00);
    wr(8'hbf);
    chk("reset_req", 8'h01, {7'h00, wdt_reset_req});
    chk("reset_n", 8'h00, {7'h00, wdt_reset_n});
    tick(101);
    chk("reset_n", 8'h01, {7'h00, wdt_reset_n});
    wr(8'h7f);
    rd(4'hc, 8'hff);
    rst(1'b0, 1'b0);
    rd(4'hc, 8'h7f);
  endtask : t_sw
  task automatic t_step;
    int n;
    wr(8'hc1);
    tick(30000);
    wr(8'hc0);
    tick(49140);
    rd(4'hc, 8'hc0);
    n = 49142;
    while (wdt_reset_req !== 1'b1 && n < 49200) begin
      tick(1);
      n++;
    end
    chk("fire_delay", 8'h01, {7'h00, n >= 49150 && n <= 49156});
  endtask : t_step
  task automatic t_halt;
    rst(1'b0, 1'b0);
    wr(8'hc1);
    hit(1'b0);
    chk("halted", 8'h01, {7'h00, halted});
    hit(1'b1);
    tick(4000);
    chk("halted", 8'h01, {7'h00, halted});
    tick(200);
    chk("halted", 8'h00, {7'h00, halted});
  endtask : t_halt
  task automatic t_opts;
    rst(1'b1, 1'b1);
    rd(4'hc, 8'hff);
    hit(1'b0);
    chk("reset_req", 8'h01, {7'h00, wdt_reset_req});
    tick(110);
    wr(8'h3f);
    chk("reset_req", 8'h01, {7'h00, wdt_reset_req});
  endtask : t_opts
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    {srst, reg_wr, reg_rd, halt_exec, ext_wake_irq} = 5'h10;
    {opt_hw_activation, opt_reset_on_halt, reg_addr, reg_wdata} = 14'h0000;
    rst(1'b0, 1'b0);
    t_sw;
    t_step;
    t_halt;
    t_opts;
    finish_test;
  end
endmodule : testbench
bind windowed_countdown_watchdog wdt_asserts chk_i (.sys_clk, .srst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .opt_hw_activation, .opt_reset_on_halt, .halt_exec,
  .ext_wake_irq, .wdt_reset_n, .wdt_reset_req, .halted);
